//--- awsc_map.vh
// Constants for the arbitrary-waveform store command checker.
// Assumes inclusion by bare name from the checker's design files.
`ifndef AWSC_MAP_VH
`define AWSC_MAP_VH
// Command opcodes
`define AWSC_OP_DL_POINTS 4'h0
`define AWSC_OP_DL_BINARY 4'h1
`define AWSC_OP_COPY 4'h2
`define AWSC_OP_DELETE 4'h3
`define AWSC_OP_CATALOG 4'h4
`define AWSC_OP_SAVE 4'h5
`define AWSC_OP_RECALL 4'h6
`define AWSC_OP_CAL 4'h7
`define AWSC_OP_NV_CHECK 4'h8
`define AWSC_OP_NV_ERASE 4'h9
`define AWSC_OP_NV_WRITE 4'ha
`define AWSC_OP_SELECT 4'hb
// Error codes
`define AWSC_E_NONE 10'h000
`define AWSC_E_CKS_BASE 10'h302
`define AWSC_E_ERASE 10'h306
`define AWSC_E_WRITE 10'h307
`define AWSC_E_NO_VOL 10'h30c
`define AWSC_E_FULL 10'h30d
`define AWSC_E_BUILTIN 10'h30e
`define AWSC_E_NAME 10'h30f
`define AWSC_E_SRC 10'h310
`define AWSC_E_NO_ARB 10'h311
`define AWSC_E_DEL_BI 10'h312
`define AWSC_E_DEL_ACT 10'h313
`define AWSC_E_TO_VOL 10'h314
`define AWSC_E_FEW_PTS 10'h316
`define AWSC_E_ODD 10'h320
`define AWSC_E_NO_STATE 10'h32a
`define AWSC_E_CAL_INV 10'h352
`define AWSC_E_CAL_50 10'h353
`define AWSC_E_CAL_64 10'h354
`define AWSC_E_CAL_30 10'h355
`define AWSC_E_CAL_31 10'h356
`define AWSC_E_CAL_33 10'h357
`define AWSC_E_CAL_60 10'h358
`define AWSC_E_CAL_62 10'h359
`define AWSC_E_CAL_32 10'h35a
// Waveform limits
`define AWSC_MIN_POINTS 14'h0008
`define AWSC_MAX_POINTS 14'h3e80
// Name characters
`define AWSC_CH_A 8'h41
`define AWSC_CH_Z 8'h5a
`define AWSC_CH_0 8'h30
`define AWSC_CH_9 8'h39
`define AWSC_CH_US 8'h5f
`define AWSC_NAME_MAX 4'h8
// Special name identifiers from the parser
`define AWSC_ID_VOLATILE 3'h0
`define AWSC_ID_OTHER 3'h1
`define AWSC_ID_BUILTIN 3'h2
// Calibration setup numbers
`define AWSC_CS_AM1 7'h1e
`define AWSC_CS_AM2 7'h1f
`define AWSC_CS_AM3 7'h20
`define AWSC_CS_LOAD 7'h21
`define AWSC_CS_NEGOFS 7'h32
`define AWSC_CS_SQPOS 7'h3c
`define AWSC_CS_SQDUTY 7'h3e
`define AWSC_CS_FLAT 7'h40
`define AWSC_CS_MAX 7'h56
`endif

//--- awsc_name_check.v
// Destination-name syntax checker for the waveform store.
// Assumes the name arrives as eight bytes, byte 0 first, with a length.
`include "awsc_map.vh"
module awsc_name_check #(
	parameter NAME_LEN = 8
) (
	input wire [8*NAME_LEN-1:0] name,
	input wire [3:0] name_len,
	output wire too_long,
	output wire bad_syntax
);
	wire [NAME_LEN-1:0] ok;
	genvar i;
	// Per-character class test; unused tail bytes are ignored
	generate
		for (i = 0; i < NAME_LEN; i = i + 1) begin : g_ch
			wire [7:0] c = name[8*i+7:8*i];
			wire letter = (c >= `AWSC_CH_A) && (c <= `AWSC_CH_Z);
			wire digit = (c >= `AWSC_CH_0) && (c <= `AWSC_CH_9);
			if (i == 0) begin : g_first
				assign ok[i] = letter;
			end else begin : g_rest
				wire in_use = (i < name_len);
				assign ok[i] = !in_use || digit || (c == `AWSC_CH_US);
			end
		end
	endgenerate
	// Spaces fail the class tests, so no separate blank check is needed
	assign too_long = (name_len > `AWSC_NAME_MAX);
	assign bad_syntax = (name_len == 4'h0) || !(&ok);
endmodule

//--- awsc_checker.v
// Command checker for the arbitrary-waveform store and nonvolatile memories.
// Assumes a parser delivering decoded commands as one-cycle strobes.
`include "awsc_map.vh"
module awsc_checker #(
	parameter NAME_LEN = 8,
	parameter SLOTS = 4,
	parameter STATES = 4
) (
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire [3:0] cmd_op,
	input wire [8*NAME_LEN-1:0] cmd_name,
	input wire [3:0] cmd_name_len,
	input wire [2:0] cmd_name_id,
	input wire [2:0] cmd_src_id,
	input wire [13:0] cmd_points,
	input wire [15:0] cmd_bytes,
	input wire [1:0] cmd_state_loc,
	input wire [6:0] cmd_cal_setup,
	input wire cmd_cal_valid,
	input wire [3:0] nv_cks_bad,
	input wire nv_op_fail,
	output reg err_valid_r,
	output reg [9:0] err_code_r,
	output reg done_r,
	output reg cat_valid_r,
	output reg cat_vol_r,
	output reg [SLOTS-1:0] cat_slot_used_r,
	output reg [8*NAME_LEN*SLOTS-1:0] cat_names_r
);
	////////////////////////////////////////////////////////////////
	// Stored state
	reg vol_loaded_r;
	reg [SLOTS-1:0] slot_used_r;
	reg [8*NAME_LEN-1:0] slot_name_r [0:SLOTS-1];
	reg [STATES-1:0] state_saved_r;
	reg active_vol_r;
	reg [SLOTS-1:0] active_slot_r;
	reg cal_50_r; // Negative offset gain step done
	reg cal_64_r; // Flatness gain step done
	reg cal_62_r; // Square-wave duty step done
	reg cal_30_r; // First modulation step done
	reg cal_31_r; // Second modulation step done
	reg cal_32_r; // Third modulation step done
	reg cal_33_r; // Load resistance given
	reg cal_60_r; // Square-wave positive offset step done
	reg [3:0] cks_pend_r;
	reg cks_busy_r;

	wire too_long;
	wire bad_syntax;
	// Pure logic, so its flags are valid in the command's own cycle
	awsc_name_check #(.NAME_LEN(NAME_LEN)) u_name (
		.name(cmd_name),
		.name_len(cmd_name_len),
		.too_long(too_long),
		.bad_syntax(bad_syntax)
	);

	////////////////////////////////////////////////////////////////
	// Slot lookup: match by name, and first free slot
	// Match ignores length; the parser must leave unused tail bytes at zero
	reg [SLOTS-1:0] match;
	reg [SLOTS-1:0] free_one;
	reg found_free;
	integer k;
	always @* begin
		match = {SLOTS{1'b0}};
		free_one = {SLOTS{1'b0}};
		found_free = 1'b0;
		for (k = 0; k < SLOTS; k = k + 1) begin
			match[k] = slot_used_r[k] && (slot_name_r[k] == cmd_name);
			if (!slot_used_r[k] && !found_free) begin
				free_one[k] = 1'b1;
				found_free = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Calibration prerequisite decode
	// Chains: 30, 31, 32, 33 in turn; 50 and 64 before their ranges, 60 before 61, 62 before 63
	reg [9:0] cal_err;
	always @* begin
		cal_err = `AWSC_E_NONE;
		if (!cmd_cal_valid || cmd_cal_setup > `AWSC_CS_MAX) begin
			cal_err = `AWSC_E_CAL_INV;
		end else if (cmd_cal_setup > `AWSC_CS_NEGOFS && cmd_cal_setup < `AWSC_CS_SQPOS
			&& !cal_50_r) begin
			cal_err = `AWSC_E_CAL_50;
		end else if (cmd_cal_setup > `AWSC_CS_FLAT && !cal_64_r) begin
			cal_err = `AWSC_E_CAL_64;
		end else if (cmd_cal_setup == `AWSC_CS_AM2 && !cal_30_r) begin
			cal_err = `AWSC_E_CAL_30;
		end else if (cmd_cal_setup == `AWSC_CS_AM3 && !cal_31_r) begin
			cal_err = `AWSC_E_CAL_31;
		end else if (cmd_cal_setup == `AWSC_CS_LOAD && !cal_32_r) begin
			cal_err = `AWSC_E_CAL_32;
		end else if (cmd_cal_setup > `AWSC_CS_LOAD && cmd_cal_setup < `AWSC_CS_NEGOFS
			&& !cal_33_r) begin
			cal_err = `AWSC_E_CAL_33;
		end else if (cmd_cal_setup == `AWSC_CS_SQPOS + 7'h01 && !cal_60_r) begin
			cal_err = `AWSC_E_CAL_60;
		end else if (cmd_cal_setup == `AWSC_CS_SQDUTY + 7'h01 && !cal_62_r) begin
			cal_err = `AWSC_E_CAL_62;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command verdict: first failing check wins, one code per command
	// Copy order: source, target, buffer, name, reserved name, capacity
	reg [9:0] verdict;
	always @* begin
		verdict = `AWSC_E_NONE;
		case (cmd_op)
			`AWSC_OP_DL_POINTS: begin
				if (cmd_points < `AWSC_MIN_POINTS || cmd_points > `AWSC_MAX_POINTS)
					verdict = `AWSC_E_FEW_PTS;
			end
			`AWSC_OP_DL_BINARY: begin
				if (cmd_bytes[0])
					verdict = `AWSC_E_ODD;
				else if (cmd_bytes[15:1] < {1'b0, `AWSC_MIN_POINTS}
					|| cmd_bytes[15:1] > {1'b0, `AWSC_MAX_POINTS})
					verdict = `AWSC_E_FEW_PTS;
			end
			`AWSC_OP_COPY: begin
				if (cmd_src_id != `AWSC_ID_VOLATILE)
					verdict = `AWSC_E_SRC;
				else if (cmd_name_id == `AWSC_ID_VOLATILE)
					verdict = `AWSC_E_TO_VOL;
				else if (!vol_loaded_r)
					verdict = `AWSC_E_NO_VOL;
				else if (too_long)
					verdict = `AWSC_E_NAME;
				else if (bad_syntax)
					verdict = `AWSC_E_NAME;
				else if (cmd_name_id == `AWSC_ID_BUILTIN)
					verdict = `AWSC_E_BUILTIN;
				else if (!(|match) && !found_free)
					verdict = `AWSC_E_FULL;
			end
			`AWSC_OP_DELETE: begin
				if (cmd_name_id == `AWSC_ID_BUILTIN)
					verdict = `AWSC_E_DEL_BI;
				else if (cmd_name_id == `AWSC_ID_VOLATILE && !vol_loaded_r)
					verdict = `AWSC_E_NO_ARB;
				else if (cmd_name_id == `AWSC_ID_VOLATILE && active_vol_r)
					verdict = `AWSC_E_DEL_ACT;
				else if (cmd_name_id != `AWSC_ID_VOLATILE && !(|match))
					verdict = `AWSC_E_NO_ARB;
				else if (cmd_name_id != `AWSC_ID_VOLATILE && |(match & active_slot_r))
					verdict = `AWSC_E_DEL_ACT;
			end
			`AWSC_OP_RECALL: begin
				if (!state_saved_r[cmd_state_loc])
					verdict = `AWSC_E_NO_STATE;
			end
			`AWSC_OP_CAL: verdict = cal_err;
			`AWSC_OP_NV_ERASE: begin
				if (nv_op_fail)
					verdict = `AWSC_E_ERASE;
			end
			`AWSC_OP_NV_WRITE: begin
				if (nv_op_fail)
					verdict = `AWSC_E_WRITE;
			end
			default: verdict = `AWSC_E_NONE;
		endcase
	end

	// Lowest pending checksum region, reported one per cycle
	reg [1:0] cks_idx;
	always @* begin
		cks_idx = 2'h3;
		if (cks_pend_r[0])
			cks_idx = 2'h0;
		else if (cks_pend_r[1])
			cks_idx = 2'h1;
		else if (cks_pend_r[2])
			cks_idx = 2'h2;
	end

	// Commands arriving while checksum codes drain are dropped, not queued
	// Trade-off: no command buffer, so the controller must pace after a check
	wire take = cmd_valid && !cks_busy_r;
	wire ok = take && (verdict == `AWSC_E_NONE);

	////////////////////////////////////////////////////////////////
	// Store updates; a refused command leaves everything untouched
	// A copy onto an existing name reuses that slot instead of taking a new one
	integer j;
	always @(posedge clk) begin
		if (rst) begin
			vol_loaded_r <= 1'b0;
			slot_used_r <= {SLOTS{1'b0}};
			state_saved_r <= {STATES{1'b0}};
			active_vol_r <= 1'b0;
			active_slot_r <= {SLOTS{1'b0}};
			// Reset forgets calibration progress; the sequence restarts afresh
			{cal_50_r, cal_64_r, cal_62_r, cal_30_r} <= 4'h0;
			{cal_31_r, cal_32_r, cal_33_r, cal_60_r} <= 4'h0;
			for (j = 0; j < SLOTS; j = j + 1)
				slot_name_r[j] <= {8*NAME_LEN{1'b0}};
		end else if (ok) begin
			case (cmd_op)
				`AWSC_OP_DL_POINTS, `AWSC_OP_DL_BINARY: vol_loaded_r <= 1'b1;
				`AWSC_OP_COPY: begin
					for (j = 0; j < SLOTS; j = j + 1) begin
						if ((|match) ? match[j] : free_one[j]) begin
							slot_used_r[j] <= 1'b1;
							slot_name_r[j] <= cmd_name;
						end
					end
				end
				`AWSC_OP_DELETE: begin
					if (cmd_name_id == `AWSC_ID_VOLATILE)
						vol_loaded_r <= 1'b0;
					else
						slot_used_r <= slot_used_r & ~match;
				end
				`AWSC_OP_SELECT: begin
					active_vol_r <= (cmd_name_id == `AWSC_ID_VOLATILE);
					active_slot_r <= (cmd_name_id == `AWSC_ID_VOLATILE) ? {SLOTS{1'b0}} : match;
				end
				`AWSC_OP_SAVE: state_saved_r[cmd_state_loc] <= 1'b1;
				`AWSC_OP_CAL: begin
					if (cmd_cal_setup == `AWSC_CS_NEGOFS) cal_50_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_FLAT) cal_64_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_SQDUTY) cal_62_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_AM1) cal_30_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_AM2) cal_31_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_AM3) cal_32_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_LOAD) cal_33_r <= 1'b1;
					if (cmd_cal_setup == `AWSC_CS_SQPOS) cal_60_r <= 1'b1;
				end
				default: vol_loaded_r <= vol_loaded_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Checksum sequencer: several mismatches are queued in region order
	// Region order follows bit order: arb, cal, system, state
	always @(posedge clk) begin
		if (rst) begin
			cks_pend_r <= 4'h0;
			cks_busy_r <= 1'b0;
		end else if (cks_busy_r) begin
			cks_pend_r[cks_idx] <= 1'b0;
			cks_busy_r <= (cks_pend_r & ~(4'h1 << cks_idx)) != 4'h0;
		end else if (take && cmd_op == `AWSC_OP_NV_CHECK && nv_cks_bad != 4'h0) begin
			cks_pend_r <= nv_cks_bad;
			cks_busy_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Error push, completion pulse and catalogue answer
	// The code follows the verdict between pushes; only err_valid_r marks one
	// Catalogue data holds until the next catalogue request
	integer m;
	always @(posedge clk) begin
		if (rst) begin
			err_valid_r <= 1'b0;
			err_code_r <= `AWSC_E_NONE;
			done_r <= 1'b0;
			cat_valid_r <= 1'b0;
			cat_vol_r <= 1'b0;
			cat_slot_used_r <= {SLOTS{1'b0}};
			cat_names_r <= {8*NAME_LEN*SLOTS{1'b0}};
		end else begin
			err_valid_r <= cks_busy_r || (take && verdict != `AWSC_E_NONE);
			err_code_r <= cks_busy_r ? (`AWSC_E_CKS_BASE + {8'h00, cks_idx}) : verdict;
			done_r <= take && !(cmd_op == `AWSC_OP_NV_CHECK && nv_cks_bad != 4'h0);
			cat_valid_r <= take && cmd_op == `AWSC_OP_CATALOG;
			if (take && cmd_op == `AWSC_OP_CATALOG) begin
				cat_vol_r <= vol_loaded_r;
				cat_slot_used_r <= slot_used_r;
				for (m = 0; m < SLOTS; m = m + 1)
					cat_names_r[8*NAME_LEN*m +: 8*NAME_LEN] <= slot_name_r[m];
			end
		end
	end
endmodule

//--- awsc_chk.sv
// Assertions on the ports of the waveform store command checker.
// Assumes one clock with a synchronous active-high reset; bound to the top.
module awsc_chk (
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire [3:0] cmd_op,
	input wire [2:0] cmd_src_id,
	input wire [13:0] cmd_points,
	input wire [15:0] cmd_bytes,
	input wire [3:0] nv_cks_bad,
	input wire nv_op_fail,
	input wire err_valid_r,
	input wire [9:0] err_code_r,
	input wire done_r,
	input wire cat_valid_r
);
	reg [4:0] cks_r;
	wire go = cmd_valid && cks_r == 5'h00;
	// Commands close behind a checksum check may be dropped, so skip them
	always @(posedge clk) begin
		if (rst)
			cks_r <= 5'h00;
		else
			cks_r <= {cks_r[3:0], cmd_valid && cmd_op == 4'h8};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// One error pulse carrying a given code
	sequence err_is(logic [9:0] c);
		err_valid_r && err_code_r == c;
	endsequence
	////////////////////////////////////////
	done_next_a: assert property (go && cmd_op != 4'h8 |=> done_r)
		else $error("command without done");
	idle_quiet_a: assert property (!cmd_valid |=> !done_r)
		else $error("done without command");
	odd_block_a: assert property (go && cmd_op == 4'h1 && cmd_bytes[0] |=> err_is(10'h320))
		else $error("odd block accepted");
	few_points_a: assert property (go && cmd_op == 4'h0 && cmd_points < 14'h0008 |=> err_is(10'h316))
		else $error("short waveform accepted");
	good_points_a: assert property (go && cmd_op == 4'h0 && cmd_points inside {[8:16000]} |=> !err_valid_r)
		else $error("legal waveform refused");
	copy_src_a: assert property (go && cmd_op == 4'h2 && cmd_src_id != 3'h0 |=> err_is(10'h310))
		else $error("bad copy source accepted");
	nv_fail_a: assert property (go && (cmd_op == 4'h9 || cmd_op == 4'ha) && nv_op_fail
		|=> err_valid_r && err_code_r == 10'h306 + $past(cmd_op == 4'ha)) else $error("nv fail code");
	cks_order_a: assert property (go && cmd_op == 4'h8 && nv_cks_bad == 4'hf
		|=> ##1 err_is(10'h302) ##1 err_is(10'h303)
		##1 err_is(10'h304) ##1 err_is(10'h305))
		else $error("checksum codes out of order");
	cat_answer_a: assert property (go && cmd_op == 4'h4 |=> cat_valid_r && !err_valid_r)
		else $error("catalogue not answered");
endmodule
bind awsc_checker awsc_chk chk_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
	.cmd_src_id(cmd_src_id), .cmd_points(cmd_points), .cmd_bytes(cmd_bytes),
	.nv_cks_bad(nv_cks_bad), .nv_op_fail(nv_op_fail), .err_valid_r(err_valid_r),
	.err_code_r(err_code_r), .done_r(done_r), .cat_valid_r(cat_valid_r));

//--- awsc_ctl_model.sv
// Controller model: presents one decoded command per call of issue.
// Assumes the bench loads the fields, then calls issue after a falling edge.
module awsc_ctl_model (
	input wire clk,
	output reg cmd_valid,
	output reg [3:0] cmd_op,
	output reg [63:0] cmd_name,
	output reg [3:0] cmd_name_len,
	output reg [2:0] cmd_name_id,
	output reg [2:0] cmd_src_id,
	output reg [13:0] cmd_points,
	output reg [15:0] cmd_bytes,
	output reg [1:0] cmd_state_loc,
	output reg [6:0] cmd_cal_setup,
	output reg cmd_cal_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cmd_valid, cmd_op, cmd_name, cmd_name_len, cmd_name_id, cmd_src_id, cmd_points,
		cmd_bytes, cmd_state_loc, cmd_cal_setup, cmd_cal_valid} = '0;
	// Released name, byte and point fields are scrambled, so the design may not lean on stale values
	task issue(input [3:0] op);
		@(negedge clk);
		cmd_op = op;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_name = ~cmd_name;
		cmd_bytes = ~cmd_bytes;
		cmd_points = ~cmd_points;
	endtask
endmodule

//--- tb_awsc_checker.sv
// Self-checking bench for the waveform store command checker.
// Assumes the controller model drives commands and the checker is bound.
module tb_awsc_checker;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] nv_cks_bad = 4'h0;
	reg nv_op_fail = 1'b0;
	wire cmd_valid, cmd_cal_valid, err_valid_r, done_r, cat_valid_r, cat_vol_r;
	wire [3:0] cmd_op, cmd_name_len, cat_slot_used_r;
	wire [63:0] cmd_name;
	wire [2:0] cmd_name_id, cmd_src_id;
	wire [13:0] cmd_points;
	wire [15:0] cmd_bytes;
	wire [1:0] cmd_state_loc;
	wire [6:0] cmd_cal_setup;
	wire [9:0] err_code_r;
	wire [255:0] cat_names_r;
	integer error_cnt = 0, checks_done = 0, seed = 78, used = 0, i, k;
	reg [67:0] seen [$];
	reg [63:0] n;
	reg [3:0] l;
	reg [7:0] r;
	reg [13:0] pt [0:3] = '{14'h0007, 14'h0008, 14'h3e80, 14'h3e81};
	reg [6:0] cs_bad [0:8] = '{7'h33, 7'h22, 7'h1f, 7'h20, 7'h21, 7'h3d, 7'h3f, 7'h41, 7'h57};
	reg [9:0] ce_bad [0:8] = '{10'h353, 10'h357, 10'h355, 10'h356, 10'h35a, 10'h358, 10'h359,
		10'h354, 10'h352};
	reg [6:0] cs_ok [0:12] = '{7'h32, 7'h33, 7'h1e, 7'h1f, 7'h20, 7'h21, 7'h22, 7'h3c, 7'h3d,
		7'h3e, 7'h3f, 7'h40, 7'h41};
	always #2 clk = ~clk;
	awsc_ctl_model ctl_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_name(cmd_name),
		.cmd_name_len(cmd_name_len), .cmd_name_id(cmd_name_id), .cmd_src_id(cmd_src_id),
		.cmd_points(cmd_points), .cmd_bytes(cmd_bytes), .cmd_state_loc(cmd_state_loc),
		.cmd_cal_setup(cmd_cal_setup), .cmd_cal_valid(cmd_cal_valid));
	awsc_checker dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_name(cmd_name), .cmd_name_len(cmd_name_len), .cmd_name_id(cmd_name_id),
		.cmd_src_id(cmd_src_id), .cmd_points(cmd_points), .cmd_bytes(cmd_bytes),
		.cmd_state_loc(cmd_state_loc), .cmd_cal_setup(cmd_cal_setup),
		.cmd_cal_valid(cmd_cal_valid), .nv_cks_bad(nv_cks_bad), .nv_op_fail(nv_op_fail),
		.err_valid_r(err_valid_r), .err_code_r(err_code_r), .done_r(done_r),
		.cat_valid_r(cat_valid_r), .cat_vol_r(cat_vol_r), .cat_slot_used_r(cat_slot_used_r),
		.cat_names_r(cat_names_r));
	////////////////////////////////////////
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One command; code zero means a clean acceptance
	task run(input [3:0] op, input [9:0] c);
		ctl_u.issue(op);
		chk(done_r, 1);
		chk(err_valid_r, c != 0);
		if (c != 0) chk(err_code_r, c);
	endtask
	task nmc(input [3:0] op, input [63:0] nn, input [3:0] ll, input [2:0] d, s, input [9:0] c);
		ctl_u.cmd_name = nn;
		ctl_u.cmd_name_len = ll;
		ctl_u.cmd_name_id = d;
		ctl_u.cmd_src_id = s;
		run(op, c);
	endtask
	function bit known(input [67:0] x);
		known = 0;
		foreach (seen[q]) if (seen[q] === x) known = 1;
	endfunction
	// Expected copy outcome for an ordinary name from the volatile buffer
	function [9:0] cp_exp(input [63:0] nn, input [3:0] ll);
		reg ok;
		ok = ll <= 8 && nn[7:0] >= 8'h41 && nn[7:0] <= 8'h5a;
		for (k = 1; k < ll && k < 8; k = k + 1)
			if (nn[8*k+:8] != 8'h5f && (nn[8*k+:8] < 8'h30 || nn[8*k+:8] > 8'h39)) ok = 0;
		cp_exp = !ok ? 10'h30f : known({ll, nn}) ? 10'h0 : used == 4 ? 10'h30d : 10'h0;
	endfunction
	task cpn(input [63:0] nn, input [3:0] ll);
		reg [9:0] c;
		c = cp_exp(nn, ll);
		nmc(4'h2, nn, ll, 3'h1, 3'h0, c);
		if (c == 0 && !known({ll, nn})) begin
			seen.push_back({ll, nn});
			used = used + 1;
		end
	endtask
	// Is a stored name present in one of the used catalogue slots?
	function bit has_name(input [63:0] x);
		has_name = 0;
		for (int q = 0; q < 4; q++)
			if (cat_slot_used_r[q] && cat_names_r[64*q+:64] === x) has_name = 1;
	endfunction
	task cat(input [3:0] cnt, input v);
		ctl_u.issue(4'h4);
		chk(cat_valid_r, 1);
		chk(cat_vol_r, v);
		chk($countones(cat_slot_used_r), cnt);
		foreach (seen[q]) chk(has_name(seen[q][63:0]), 1);
	endtask
	// Checksum errors start two cycles after the check, one a cycle in region order
	task nvc(input [3:0] b);
		nv_cks_bad = b;
		ctl_u.issue(4'h8);
		chk(done_r, b == 0);
		chk(err_valid_r, 0);
		@(negedge clk);
		for (k = 0; k < 4; k = k + 1) if (b[k]) begin
			chk(err_valid_r, 1);
			chk(err_code_r, 10'h302 + k);
			@(negedge clk);
		end
		repeat (4) @(negedge clk);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		nmc(4'h2, 64'h3141, 4'h2, 3'h1, 3'h0, 10'h30c);
		nmc(4'h2, 64'h3141, 4'h2, 3'h1, 3'h1, 10'h310);
		nmc(4'h2, 64'h3141, 4'h2, 3'h0, 3'h0, 10'h314);
		for (i = 0; i < 4; i = i + 1) begin
			ctl_u.cmd_points = pt[i];
			run(4'h0, pt[i] < 8 || pt[i] > 16000 ? 10'h316 : 10'h0);
		end
		for (i = 0; i < 6; i = i + 1) begin
			ctl_u.cmd_bytes = i < 2 ? 16'h0010 + i : {$random(seed)} % 40;
			run(4'h1, ctl_u.cmd_bytes[0] ? 10'h320 : ctl_u.cmd_bytes < 16 ? 10'h316 : 10'h0);
		end
		nmc(4'h2, 64'h3141, 4'h2, 3'h2, 3'h0, 10'h30e);
		for (i = 0; i < 16; i = i + 1) begin
			l = 1 + {$random(seed)} % 10;
			n = 0;
			for (k = 0; k < l && k < 8; k = k + 1) begin
				r = {$random(seed)} % 16;
				n[8*k+:8] = r < 10 ? 8'h30 + r : r == 10 ? 8'h5f : r == 11 ? 8'h20 : 8'h41 + r;
			end
			if ({$random(seed)} % 4 != 0) n[7:0] = 8'h41 + r;
			cpn(n, l);
		end
		for (i = 0; used < 4; i = i + 1) cpn({48'h0, 8'h30 + i[7:0], 8'h58}, 4'h2);
		cpn(64'h5f5f5f5f5f5f5f56, 4'h8);
		cat(4, 1);
		{l, n} = seen.pop_front();
		nmc(4'h3, n, l, 3'h1, 3'h0, 10'h0);
		used = used - 1;
		cat(3, 1);
		cpn(n, l);
		nmc(4'hb, seen[0][63:0], seen[0][67:64], 3'h1, 3'h0, 10'h0);
		nmc(4'h3, seen[0][63:0], seen[0][67:64], 3'h1, 3'h0, 10'h313);
		nmc(4'h3, 64'h3141, 4'h2, 3'h2, 3'h0, 10'h312);
		nmc(4'h3, 64'h3939393939393959, 4'h8, 3'h1, 3'h0, 10'h311);
		nmc(4'h3, 64'h0, 4'h0, 3'h0, 3'h0, 10'h0);
		cat(4, 0);
		nmc(4'h2, 64'h3141, 4'h2, 3'h1, 3'h0, 10'h30c);
		ctl_u.cmd_state_loc = 2'h2;
		run(4'h6, 10'h32a);
		run(4'h5, 10'h0);
		run(4'h6, 10'h0);
		ctl_u.cmd_state_loc = 2'h1;
		run(4'h6, 10'h32a);
		ctl_u.cmd_cal_setup = 7'h32;
		run(4'h7, 10'h352);
		ctl_u.cmd_cal_valid = 1'b1;
		for (i = 0; i < 9; i = i + 1) begin
			ctl_u.cmd_cal_setup = cs_bad[i];
			run(4'h7, ce_bad[i]);
		end
		for (i = 0; i < 13; i = i + 1) begin
			ctl_u.cmd_cal_setup = cs_ok[i];
			run(4'h7, 10'h0);
		end
		for (i = 0; i < 4; i = i + 1) begin
			nv_op_fail = i[1];
			run(4'h9 + i[0], i[1] ? 10'h306 + i[0] : 10'h0);
		end
		nv_op_fail = 1'b0;
		nvc(4'hf);
		nvc(4'h0);
		for (i = 0; i < 4; i = i + 1) nvc(4'($random(seed)));
		give_verdict;
	end
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		give_verdict;
	end
endmodule
